// file: src/dwt_pkg.sv
package dwt_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_LO_ADDR = 32'h0000_0050;
  localparam logic [31:0] CTRL_HI_ADDR = 32'h0000_0054;
  localparam logic [31:0] STAT_ADDR = 32'h0000_0060;
  localparam logic [63:0] CTRL_RESET = 64'h0000_0000_0000_0000;
  // Writable bits while unlocked: 51:50 and 48:0
  localparam logic [63:0] CTRL_WR_MASK = 64'h000D_FFFF_FFFF_FFFF;
  localparam logic [63:0] CTRL_GO_MASK = 64'h0000_0000_0000_0001;
  localparam logic [63:0] LANE_LO = 64'h0000_0000_FFFF_FFFF;
  localparam logic [63:0] LANE_HI = 64'hFFFF_FFFF_0000_0000;
  localparam logic [31:0] RDATA_NONE = 32'h0000_0000;

  // Lock and source encodings
  localparam logic [1:0] LOCK_NONE = 2'h0;
  localparam logic [1:0] LOCK_CFG = 2'h1;
  localparam logic [1:0] SRC_HW = 2'h1;
  localparam logic [1:0] SRC_CNT = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;

  // ----------------------------------------------------------------
  // Timing and widths
  // ----------------------------------------------------------------
  localparam int unsigned SAMPLE_UNIT_CLK = 400000;
  localparam int PRE_W = 19;
  localparam int THR_SHIFT = 15;
  localparam logic [3:0] MON_PAD = 4'h0;
  localparam int MON_W = 11;
  localparam int SCNT_W = 29;

  // Control register layout, bit 63 first
  typedef struct packed {
    logic [11:0] rsv_hi;
    logic [1:0] lock;
    logic rsv_49;
    logic [7:0] sampling_window_length;
    logic [12:0] write_burst_threshold;
    logic [5:0] throttle_duration;
    logic [6:0] monitor_window_length;
    logic [11:0] window_write_cap;
    logic [1:0] write_throttle_source;
    logic software_write_throttle_go;
  } dwt_ctrl_t;

  // Status register layout, bit 31 first
  typedef struct packed {
    logic [3:0] rsv_a;
    logic [11:0] mon_count;
    logic [1:0] rsv_b;
    logic [5:0] windows_left;
    logic [4:0] rsv_c;
    logic counter_period;
    logic blocked;
    logic active;
  } dwt_stat_t;

  // Captured AHB address phase
  typedef struct packed {
    logic wr_lo;
    logic wr_hi;
  } dwt_ap_t;

  typedef enum logic {DWT_SAMPLE, DWT_THROTTLE} dwt_state_t;
endpackage : dwt_pkg

// file: src/dwt_throttle.sv
// Functional notes
// - Lock field 51:50: 00 all writable, 01 only start bits writable, 10 none, 11 reserved.
// - Once any lock bit is one, covered bits of both throttle registers ignore writes.
// - Sampling window is the 8-bit field 48:41 times 4*10^5 host clocks, counting 32-byte chunks.
// - More chunks than the threshold in one sampling window invokes counter throttling.
// - Threshold in chunks is the 13-bit field 40:28 times 2^15.
// - Counter throttling lasts the number of sampling windows in field 27:22 (0 to 63).
// - Monitoring window is field 21:15 with four zero bits below, 0 to 2032 clocks.
// - While throttling, chunks per monitoring window are counted and writes blocked at the cap.
// - Field 14:3 is the cap of chunks, 0 to 4095, per monitoring window.
// - Source field 2:1: 00 off, 01 hardware signal, 10 counter and threshold, 11 reserved.
// - In signal mode throttle while the signal is high; on its fall stop and clear counters.
// - Start bit 0 throttles while one; clearing it stops and clears the monitoring counters.
module dwt_throttle
  import dwt_pkg::*;
#(
  parameter int unsigned P_SAMPLE_UNIT = SAMPLE_UNIT_CLK // Clocks per window unit
) (
  input wire logic I_MCLK, // Host clock
  input wire logic I_RST, // Sync reset, high
  input wire logic I_HSEL, // AHB select
  input wire logic [31:0] I_HADDR, // AHB address
  input wire logic [1:0] I_HTRANS, // AHB transfer type
  input wire logic I_HWRITE, // AHB write
  input wire logic [2:0] I_HSIZE, // AHB size, word only
  input wire logic [31:0] I_HWDATA, // AHB write data
  input wire logic I_HREADY, // AHB bus ready
  output logic [31:0] O_HRDATA, // AHB read data
  output logic O_HREADYOUT, // AHB slave ready
  output logic O_HRESP, // AHB response
  input wire logic I_THERM_ON, // Thermal request pin
  input wire logic I_WR_VALID, // Write chunk offered
  output logic O_WR_READY, // Write chunk allowed
  output logic O_THROTTLE, // Throttling in effect
  output logic [1:0] O_CFG_LOCK // Lock state for read side
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  dwt_ctrl_t ctrl;
  dwt_ctrl_t next_ctrl;
  dwt_ap_t ap;
  dwt_stat_t stat;
  dwt_state_t state;
  logic ap_take;
  logic [63:0] lock_mask;
  logic therm_s1;
  logic therm_s2;
  logic active;
  logic acc;
  logic cnt_mode;
  logic invoke;
  logic finish;
  logic samp_clr;
  logic pre_tick;
  logic sample_end;
  logic mon_tick;
  logic [11:0] mon_cnt;
  logic [SCNT_W-1:0] samp_cnt;
  logic [SCNT_W-1:0] thr_chunks;
  logic [5:0] remain;

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  // Zero wait states: a write lands in its data phase
  assign ap_take = I_HSEL && I_HTRANS[1] && I_HREADY;

  // Address phase capture
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      ap <= '0;
    end else begin
      ap.wr_lo <= ap_take && I_HWRITE && (I_HADDR == CTRL_LO_ADDR);
      ap.wr_hi <= ap_take && I_HWRITE && (I_HADDR == CTRL_HI_ADDR);
    end
  end

  // Writable bits shrink once locked; lock bits freeze themselves
  always_comb begin
    if (ctrl.lock == LOCK_NONE) begin
      lock_mask = CTRL_WR_MASK;
    end else if (ctrl.lock == LOCK_CFG) begin
      lock_mask = CTRL_GO_MASK;
    end else begin
      lock_mask = '0;
    end
  end

  // Merge write data into the addressed word
  always_comb begin
    logic [63:0] m;
    m = '0;
    if (ap.wr_lo) begin
      m = LANE_LO & lock_mask;
    end else if (ap.wr_hi) begin
      m = LANE_HI & lock_mask;
    end
    next_ctrl = dwt_ctrl_t'((ctrl & ~m) | ({I_HWDATA, I_HWDATA} & m));
  end

  // Control register
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      ctrl <= dwt_ctrl_t'(CTRL_RESET);
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // Read data from next value, so a read right after a write sees it
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      O_HRDATA <= RDATA_NONE;
    end else if (ap_take && !I_HWRITE) begin
      if (I_HADDR == CTRL_LO_ADDR) begin
        O_HRDATA <= next_ctrl[31:0];
      end else if (I_HADDR == CTRL_HI_ADDR) begin
        O_HRDATA <= next_ctrl[63:32];
      end else if (I_HADDR == STAT_ADDR) begin
        O_HRDATA <= stat;
      end else begin
        O_HRDATA <= RDATA_NONE;
      end
    end else begin
      O_HRDATA <= RDATA_NONE;
    end
  end

  // Never stalls, never errors
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      O_HREADYOUT <= 1'b1;
      O_HRESP <= HRESP_OKAY;
    end else begin
      O_HREADYOUT <= 1'b1;
      O_HRESP <= HRESP_OKAY;
    end
  end

  // Status view of block state
  always_comb begin
    stat = '0;
    stat.mon_count = mon_cnt;
    stat.windows_left = remain;
    stat.counter_period = (state == DWT_THROTTLE);
    stat.blocked = !O_WR_READY;
    stat.active = O_THROTTLE;
  end

  // ----------------------------------------------------------------
  // Throttle sources
  // ----------------------------------------------------------------
  // Pin synchroniser
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      therm_s1 <= 1'b0;
      therm_s2 <= 1'b0;
    end else begin
      therm_s1 <= I_THERM_ON;
      therm_s2 <= therm_s1;
    end
  end

  // Reserved source 11 acts like off
  assign active = ctrl.software_write_throttle_go
    || ((ctrl.write_throttle_source == SRC_HW) && therm_s2)
    || (state == DWT_THROTTLE);
  assign acc = I_WR_VALID && O_WR_READY;

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      O_THROTTLE <= 1'b0;
      O_CFG_LOCK <= LOCK_NONE;
    end else begin
      O_THROTTLE <= active;
      O_CFG_LOCK <= ctrl.lock;
    end
  end

  // ----------------------------------------------------------------
  // Sampling window and invocation
  // ----------------------------------------------------------------
  // Window field of zero disables the counter mechanism
  assign cnt_mode = (ctrl.write_throttle_source == SRC_CNT) && (ctrl.sampling_window_length != '0);
  assign thr_chunks = SCNT_W'(ctrl.write_burst_threshold) << THR_SHIFT;
  assign invoke = cnt_mode && (state == DWT_SAMPLE) && (samp_cnt > thr_chunks)
    && (ctrl.throttle_duration != '0);
  assign finish = cnt_mode && (state == DWT_THROTTLE) && sample_end && (remain == 6'h1);
  assign samp_clr = !cnt_mode || invoke || finish;

  // Unit prescaler then unit count
  dwt_tick_cnt #(.W(PRE_W)) u_pre (
    .i_clk(I_MCLK),
    .i_rst(I_RST),
    .i_clr(samp_clr),
    .i_en(1'b1),
    .i_limit(PRE_W'(P_SAMPLE_UNIT)),
    .o_tick(pre_tick)
  );
  dwt_tick_cnt #(.W(8)) u_units (
    .i_clk(I_MCLK),
    .i_rst(I_RST),
    .i_clr(samp_clr),
    .i_en(pre_tick),
    .i_limit(ctrl.sampling_window_length),
    .o_tick(sample_end)
  );

  // Chunks in the current sampling window, saturating; a boundary chunk opens the next one
  always_ff @(posedge I_MCLK) begin
    if (I_RST || samp_clr || sample_end) begin
      samp_cnt <= SCNT_W'(!I_RST && !samp_clr && acc && (state == DWT_SAMPLE));
    end else if (acc && (state == DWT_SAMPLE) && !(&samp_cnt)) begin
      samp_cnt <= samp_cnt + SCNT_W'(1);
    end
  end

  // Counter period of whole sampling windows
  always_ff @(posedge I_MCLK) begin
    if (I_RST || !cnt_mode) begin
      state <= DWT_SAMPLE;
      remain <= '0;
    end else begin
      case (state)
        DWT_SAMPLE: begin
          if (invoke) begin
            state <= DWT_THROTTLE;
            remain <= ctrl.throttle_duration;
          end
        end
        DWT_THROTTLE: begin
          if (sample_end) begin
            remain <= remain - 6'h1;
            if (remain == 6'h1) begin
              state <= DWT_SAMPLE;
            end
          end
        end
        default: begin
          state <= DWT_SAMPLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Monitoring window and write cap
  // ----------------------------------------------------------------
  dwt_tick_cnt #(.W(MON_W)) u_mon (
    .i_clk(I_MCLK),
    .i_rst(I_RST),
    .i_clr(!active),
    .i_en(active),
    .i_limit({ctrl.monitor_window_length, MON_PAD}),
    .o_tick(mon_tick)
  );

  // Chunks in this monitoring window; cleared whenever throttling stops
  always_ff @(posedge I_MCLK) begin
    if (I_RST || !active || mon_tick) begin
      mon_cnt <= '0;
    end else if (acc && !(&mon_cnt)) begin
      mon_cnt <= mon_cnt + 12'h1;
    end
  end

  // Ready is registered, so the block starts one cycle after the cap
  always_ff @(posedge I_MCLK) begin
    if (I_RST || !active) begin
      O_WR_READY <= 1'b1;
    end else if (mon_tick) begin
      O_WR_READY <= (ctrl.window_write_cap != '0);
    end else if ((13'(mon_cnt) + 13'(acc)) >= 13'(ctrl.window_write_cap)) begin
      O_WR_READY <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [31:0] samp_gap;
  logic [MON_W-1:0] mon_gap;

  // Cycle distance since window restart, for spacing checks
  always_ff @(posedge I_MCLK) begin
    if (I_RST || samp_clr || sample_end) begin
      samp_gap <= '0;
    end else begin
      samp_gap <= samp_gap + 32'h1;
    end
  end
  always_ff @(posedge I_MCLK) begin
    if (I_RST || !active || mon_tick) begin
      mon_gap <= '0;
    end else begin
      mon_gap <= mon_gap + 11'h1;
    end
  end

  AST_LOCK_ALL: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (ctrl.lock[1]) |=> $stable(ctrl))
    else $error("Fully locked control register changed");
  AST_LOCK_STICKY: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (ctrl.lock != LOCK_NONE) |=> (ctrl[63:1] == $past(ctrl[63:1])))
    else $error("Locked configuration bits changed");
  AST_SAMPLE_LEN: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (sample_end && cnt_mode && !$past(samp_clr))
      |-> (samp_gap + 32'h1 == 32'(ctrl.sampling_window_length) * P_SAMPLE_UNIT))
    else $error("Sampling window length wrong");
  AST_INVOKE: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (cnt_mode && state == DWT_SAMPLE && ctrl.throttle_duration != '0
      && samp_cnt > (SCNT_W'(ctrl.write_burst_threshold) * SCNT_W'(32768)))
      |=> (state == DWT_THROTTLE) ##1 O_THROTTLE)
    else $error("Threshold exceeded without throttling");
  AST_NO_EARLY: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (state == DWT_SAMPLE && samp_cnt <= thr_chunks) |=> (state == DWT_SAMPLE))
    else $error("Throttling invoked below threshold");
  AST_DURATION: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (state == DWT_SAMPLE ##1 state == DWT_THROTTLE) |-> (remain == $past(ctrl.throttle_duration)))
    else $error("Period not loaded from duration field");
  AST_MON_LEN: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (mon_tick && ctrl.monitor_window_length != '0 && $stable(ctrl.monitor_window_length))
      |-> (mon_gap == ({ctrl.monitor_window_length, MON_PAD} - 11'h1)))
    else $error("Monitoring window length wrong");
  AST_BLOCK_HOLD: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (!O_WR_READY && active && !mon_tick) |=> !O_WR_READY)
    else $error("Block released inside monitoring window");
  AST_CAP: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (active && !mon_tick && 13'(mon_cnt) + 13'(acc) >= 13'(ctrl.window_write_cap)) |=> !O_WR_READY)
    else $error("Writes not blocked at cap");
  AST_SRC_OFF: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (ctrl.write_throttle_source != SRC_HW && ctrl.write_throttle_source != SRC_CNT
      && !ctrl.software_write_throttle_go)[*2] |=> !O_THROTTLE)
    else $error("Throttle with no source selected");
  AST_HW_ON: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (ctrl.write_throttle_source == SRC_HW && therm_s2) |=> O_THROTTLE)
    else $error("Signal mode did not throttle");
  AST_IDLE_CLEAR: assert property (@(posedge I_MCLK) disable iff (I_RST)
    !active |=> (mon_cnt == '0 && O_WR_READY))
    else $error("Monitoring state not cleared when idle");
  AST_GO: assert property (@(posedge I_MCLK) disable iff (I_RST)
    ctrl.software_write_throttle_go |=> O_THROTTLE)
    else $error("Start bit did not throttle");
  AST_EXPIRE: assert property (@(posedge I_MCLK) disable iff (I_RST)
    finish |=> (state == DWT_SAMPLE && samp_cnt == '0))
    else $error("Period expiry did not restart sampling");
  AST_RESET: assert property (@(posedge I_MCLK) disable iff (1'b0)
    I_RST |=> (ctrl == dwt_ctrl_t'(CTRL_RESET) && !O_THROTTLE))
    else $error("Control not cleared by reset");

  COV_INVOKE: cover property (@(posedge I_MCLK) disable iff (I_RST) invoke);
  COV_CAP_BLOCK: cover property (@(posedge I_MCLK) disable iff (I_RST)
    active && !O_WR_READY && I_WR_VALID);
  COV_HW: cover property (@(posedge I_MCLK) disable iff (I_RST)
    ctrl.write_throttle_source == SRC_HW && $fell(therm_s2));
  COV_LOCK: cover property (@(posedge I_MCLK) disable iff (I_RST) ap.wr_hi && ctrl.lock != '0);
endmodule : dwt_throttle

// file: src/dwt_tick_cnt.sv
module dwt_tick_cnt #(
  parameter int W = 8
) (
  input wire logic i_clk, // Host clock
  input wire logic i_rst, // Sync reset
  input wire logic i_clr, // Restart window
  input wire logic i_en, // Count this cycle
  input wire logic [W-1:0] i_limit, // Window length
  output logic o_tick // Last cycle of window
);
  logic [W-1:0] cnt;

  // Limit of 0 or 1 ticks every enabled cycle
  assign o_tick = i_en && (({1'b0, cnt} + {{W{1'b0}}, 1'b1}) >= {1'b0, i_limit});

  // Window position
  always_ff @(posedge i_clk) begin
    if (i_rst || i_clr || o_tick) begin
      cnt <= '0;
    end else if (i_en) begin
      cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule : dwt_tick_cnt

// file: verification/dwt_throttle_tb.sv
module dwt_throttle_tb
  import dwt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned UNIT = 8;
  logic mclk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, therm = 1'b0, offer = 1'b0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rdata, rd;
  logic [1:0] htrans = 2'h0;
  logic hready, hresp, valid, ready, thr;
  logic [1:0] lock;
  logic [15:0] taken, t0;
  int err_count = 0, samples_checked = 0;
  // ----------------------------------------------------------------
  // Clock, device and partner
  // ----------------------------------------------------------------
  always #25 mclk = ~mclk;
  dwt_throttle #(.P_SAMPLE_UNIT(UNIT)) i_dwt_throttle (
    .I_MCLK(mclk), .I_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
    .O_HRDATA(rdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .I_THERM_ON(therm),
    .I_WR_VALID(valid), .O_WR_READY(ready), .O_THROTTLE(thr), .O_CFG_LOCK(lock));
  dwt_wr_src i_dwt_wr_src (.i_clk(mclk), .i_rst(rst), .i_offer(offer), .i_ready(ready),
    .o_valid(valid), .o_taken(taken));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  // Waits on hready under a bound; a hang ends the run
  task automatic hwait;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      err_count++;
      final_report();
    end
  endtask : hwait
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hwait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hwait();
    rd = rdata;
    chk("hresp", {31'h0, hresp}, {31'h0, HRESP_OKAY});
    chk("hready", {31'h0, hready}, 32'h1);
  endtask : ahb
  task automatic wait_thr(input logic v);
    int n;
    n = 0;
    while (thr !== v && n < 200) begin
      @(posedge mclk);
      n++;
    end
    if (thr !== v) begin
      err_count++;
      final_report();
    end
  endtask : wait_thr
  function automatic logic [31:0] lo(logic go, logic [1:0] src, logic [11:0] cap,
    logic [6:0] mon, logic [5:0] dur);
    return {4'h0, dur, mon, cap, src, go};
  endfunction : lo
  task automatic do_reset;
    rst <= 1'b1;
    cyc(10);
    rst <= 1'b0;
    cyc(1);
  endtask : do_reset
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    ahb(1'b0, CTRL_LO_ADDR, 32'h0);
    chk("ctrl_lo", rd, 32'h0);
    ahb(1'b0, CTRL_HI_ADDR, 32'h0);
    chk("ctrl_hi", rd, 32'h0);
    ahb(1'b0, 32'h0000_0058, 32'h0);
    chk("unmapped", rd, 32'h0);
    ahb(1'b1, CTRL_HI_ADDR, 32'hFFF1_FFFF);
    ahb(1'b0, CTRL_HI_ADDR, 32'h0);
    chk("ctrl_hi_rsv", rd, 32'h0001_FFFF);
    $display("test reset done");
  endtask : t_reset
  // Cap per 16-clock window: 64 clocks hold four windows exactly
  task automatic t_cap(input logic [11:0] cap);
    ahb(1'b1, CTRL_LO_ADDR, lo(1'b1, 2'h0, cap, 7'h01, 6'h00));
    offer <= 1'b1;
    wait_thr(1'b1);
    cyc(40);
    t0 = taken;
    cyc(64);
    chk("chunks", {16'h0, taken - t0}, {18'h0, cap, 2'h0});
    ahb(1'b1, CTRL_LO_ADDR, lo(1'b0, 2'h0, cap, 7'h01, 6'h00));
    wait_thr(1'b0);
    cyc(2);
    chk("ready_after_stop", {31'h0, ready}, 32'h1);
    offer <= 1'b0;
    $display("test cap %0d done", cap);
  endtask : t_cap
  task automatic t_pin;
    ahb(1'b1, CTRL_LO_ADDR, lo(1'b0, SRC_HW, 12'h000, 7'h01, 6'h00));
    offer <= 1'b1;
    therm <= 1'b1;
    wait_thr(1'b1);
    cyc(4);
    chk("blocked_pin", {31'h0, ready}, 32'h0);
    ahb(1'b0, STAT_ADDR, 32'h0);
    chk("stat_pin", {29'h0, rd[2:0]}, 32'h3);
    therm <= 1'b0;
    wait_thr(1'b0);
    cyc(2);
    chk("ready_pin_off", {31'h0, ready}, 32'h1);
    for (int s = 0; s < 4; s += 3) begin
      ahb(1'b1, CTRL_LO_ADDR, lo(1'b0, 2'(s), 12'h000, 7'h01, 6'h00));
      therm <= 1'b1;
      cyc(20);
      chk("pin_ignored", {31'h0, thr}, 32'h0);
      therm <= 1'b0;
    end
    offer <= 1'b0;
    $display("test pin done");
  endtask : t_pin
  // Zero threshold: one chunk invokes a period of two 8-clock windows
  task automatic t_counter;
    int n;
    ahb(1'b1, CTRL_HI_ADDR, 32'h0000_0200);
    ahb(1'b1, CTRL_LO_ADDR, lo(1'b0, SRC_CNT, 12'h000, 7'h01, 6'h02));
    cyc(20);
    chk("no_chunk_idle", {31'h0, thr}, 32'h0);
    offer <= 1'b1;
    cyc(1);
    offer <= 1'b0;
    wait_thr(1'b1);
    n = 0;
    while (thr === 1'b1 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    chk("period_len", 32'(n), 32'(2 * UNIT));
    cyc(30);
    chk("resumed_idle", {31'h0, thr}, 32'h0);
    $display("test counter done");
  endtask : t_counter
  task automatic t_lock;
    ahb(1'b1, CTRL_HI_ADDR, 32'h0004_0000);
    ahb(1'b1, CTRL_LO_ADDR, 32'hFFFF_FFFF);
    ahb(1'b0, CTRL_LO_ADDR, 32'h0);
    chk("lock01_lo", rd, 32'h0000_0001);
    ahb(1'b1, CTRL_HI_ADDR, 32'h0000_0000);
    ahb(1'b0, CTRL_HI_ADDR, 32'h0);
    chk("lock01_hi", rd, 32'h0004_0000);
    chk("lock_port", {30'h0, lock}, {30'h0, LOCK_CFG});
    do_reset();
    ahb(1'b1, CTRL_HI_ADDR, 32'h0008_0000);
    ahb(1'b1, CTRL_LO_ADDR, 32'h0000_0001);
    ahb(1'b0, CTRL_LO_ADDR, 32'h0);
    chk("lock10_lo", rd, 32'h0);
    $display("test lock done");
  endtask : t_lock
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    t_reset();
    do_reset();
    t_cap(12'h002);
    t_cap(12'h000);
    t_cap(12'h003);
    t_pin();
    do_reset();
    t_counter();
    do_reset();
    t_lock();
    final_report();
  end
endmodule : dwt_throttle_tb

// file: verification/dwt_wr_src.sv
module dwt_wr_src (
  input wire logic i_clk, // Host clock
  input wire logic i_rst, // Sync reset
  input wire logic i_offer, // Keep chunks coming
  input wire logic i_ready, // Device allows chunk
  output logic o_valid, // Chunk offered
  output logic [15:0] o_taken // Chunks accepted
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Host write source
  // ----------------------------------------------------------------
  // At most one chunk per cycle, offer held until the device takes it
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_valid <= 1'b0;
    end else if (!o_valid || i_ready) begin
      o_valid <= i_offer;
    end
  end
  // Count only chunks the device really took
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_taken <= 16'h0000;
    end else if (o_valid && i_ready) begin
      o_taken <= o_taken + 16'h0001;
    end
  end
endmodule : dwt_wr_src
